// *** logic/cld_defs.svh ***
// Constants for the communications logic datapath
// Function
// - Single log-max of two metric registers writes one result to a data register.
// - Add max adds high half to first pair, low half to second; saturated max.
// - Subtract max subtracts halves likewise; keeps larger saturated difference.
// - Despread samples are eight 16-bit complex values; imaginary upper byte.
// - Code pair gives eight 2-bit codes plus 48 bits; set bit means -1.
// - Each despread shifts the code history pair right by 16 bits.
// - A same-line code history load wins over the instruction's shift.
// - Despread accumulation saturates instead of wrapping.
// - Accumulate despread adds complex products of samples 0 to 7 to metric.
// - Products are by plus or minus one, aligned low, sums sign-extended.
// - Single despread result is one word: real low half, imaginary high half.
// - Transfer form copies old metric value out while metric takes new result.
// - Dual form yields two words: samples 0 to 3 low, 4 to 7 high.
// - Eight complex multiply-accumulates complete in one cycle.
// - Accumulation lengths of four, eight and multiples of eight are supported.
// - Correlation runs 16 delays, sample m times code m-k+15, cut gated.
// - Each correlation shifts the four-register code history right by 16.
// - Zero-before-sum option clears target metrics before summation.
// - Wide option uses 32-bit inputs, 64-bit accumulators, eight delays.
// - Positive cut k suppresses code indices k and above.
// - Negative cut -k suppresses indices below k; absent cut means zero.
// - Correction looked up from seven low difference bits; zero beyond.
`ifndef CLD_DEFS_SVH
`define CLD_DEFS_SVH
`define CLD_NTR 32
`define CLD_NHIST 4
`define CLD_HIST_SHIFT 16
`define CLD_NDELAY 16
`define CLD_NDELAY_EXT 8
`define CLD_CORR_LIMIT 128
`define CLD_TR_RESET 32'h0000_0000
`endif

// *** logic/cld_pkg.sv ***
// Types for the communications logic datapath
`default_nettype none
package cld_pkg;
  typedef enum logic [3:0] {
    CLD_NOP, CLD_TR_LOAD, CLD_LOGMAX_SR, CLD_ADD_MAX, CLD_SUB_MAX,
    CLD_DSP_ACC, CLD_DSP_XFER, CLD_DSP_DUAL, CLD_XCORR
  } cld_op_e;
  typedef struct packed {
    logic valid;
    cld_op_e op;
    logic [4:0] dst;
    logic [4:0] srcM;
    logic [4:0] srcN;
    logic [4:0] rdst;
    logic useLog;
    logic zeroBeforeSum;
    logic widePrecision;
    logic signed [5:0] cut;
    logic [127:0] quad;
  } cld_instr_s;
  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [31:0] data;
  } cld_hload_s;
  typedef struct packed {
    logic valid;
    logic dbl;
    logic [4:0] idx;
    logic [63:0] data;
  } cld_rfwr_s;
endpackage : cld_pkg
`default_nettype wire

// *** logic/cld_cmac.sv ***
// Gated complex multiply-accumulate of samples against 2-bit codes
`timescale 1ns/1ps
`default_nettype none
module cld_cmac #(
  parameter int SW = 8,
  parameter int NS = 8
) (
  input wire logic [2*SW*NS-1:0] samples,
  input wire logic [2*NS-1:0] code,
  input wire logic [NS-1:0] gate,
  output logic signed [SW+4:0] loRe,
  output logic signed [SW+4:0] loIm,
  output logic signed [SW+4:0] allRe,
  output logic signed [SW+4:0] allIm
);
  logic signed [SW+4:0] termRe [NS];
  logic signed [SW+4:0] termIm [NS];
  genvar i;
  for (i = 0; i < NS; i++) begin : g_s
    logic signed [SW+4:0] dRe, dIm, pRR, pII, pRI, pIR;
    assign dRe = (SW+5)'($signed(samples[2*SW*i +: SW]));
    assign dIm = (SW+5)'($signed(samples[2*SW*i+SW +: SW]));
    assign pRR = code[2*i] ? -dRe : dRe;
    assign pII = code[2*i+1] ? -dIm : dIm;
    assign pRI = code[2*i] ? -dIm : dIm;
    assign pIR = code[2*i+1] ? -dRe : dRe;
    assign termRe[i] = gate[i] ? pRR - pII : '0;
    assign termIm[i] = gate[i] ? pRI + pIR : '0;
  end
  always_comb begin
    loRe = '0;
    loIm = '0;
    allRe = '0;
    allIm = '0;
    for (int n = 0; n < NS; n++) begin
      allRe = allRe + termRe[n];
      allIm = allIm + termIm[n];
      if (n < NS / 2) begin
        loRe = loRe + termRe[n];
        loIm = loIm + termIm[n];
      end
    end
  end
endmodule : cld_cmac
`default_nettype wire

// *** logic/cld_logmax.sv ***
// Saturated max with optional log-max correction term
`timescale 1ns/1ps
`default_nettype none
`include "cld_defs.svh"
module cld_logmax (
  input wire logic signed [31:0] a,
  input wire logic signed [31:0] b,
  input wire logic useLog,
  output logic signed [31:0] res
);
  logic signed [32:0] diff, mag, sum;
  logic [4:0] corr;
  function automatic logic [4:0] lut(input logic [6:0] v);
    if (v < 7'h02) return 5'h16;
    else if (v < 7'h04) return 5'h15;
    else if (v < 7'h06) return 5'h14;
    else if (v < 7'h08) return 5'h13;
    else if (v < 7'h0a) return 5'h12;
    else if (v < 7'h0c) return 5'h11;
    else if (v < 7'h10) return 5'h10;
    else if (v < 7'h14) return 5'h0e;
    else if (v < 7'h18) return 5'h0d;
    else if (v < 7'h1c) return 5'h0c;
    else if (v < 7'h20) return 5'h0b;
    else if (v < 7'h24) return 5'h0a;
    else if (v < 7'h28) return 5'h08;
    else if (v < 7'h30) return 5'h07;
    else if (v < 7'h38) return 5'h06;
    else if (v < 7'h40) return 5'h05;
    else if (v < 7'h50) return 5'h03;
    else if (v < 7'h60) return 5'h02;
    else return 5'h01;
  endfunction : lut
  always_comb begin
    diff = 33'(a) - 33'(b);
    mag = diff[32] ? ~diff : diff;
    corr = (!useLog || mag >= 33'sd`CLD_CORR_LIMIT) ? 5'h00 : lut(mag[6:0]);
    sum = (diff[32] ? 33'(b) : 33'(a)) + 33'(corr);
    if (sum > 33'sh0_7fff_ffff) res = 32'sh7fff_ffff;
    else res = sum[31:0];
  end
endmodule : cld_logmax
`default_nettype wire

// *** logic/cld_datapath.sv ***
// Communications logic datapath: trellis max, despread and correlation
`timescale 1ns/1ps
`default_nettype none
`include "cld_defs.svh"
module cld_datapath (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cld_pkg::cld_instr_s instr,
  input wire cld_pkg::cld_hload_s hLoad,
  output var cld_pkg::cld_rfwr_s rfWr_r
);
  logic [31:0] trR [`CLD_NTR];
  logic [31:0] trNxt [`CLD_NTR];
  logic [`CLD_NHIST-1:0][31:0] thrR, thrNxt;
  logic [32*`CLD_NHIST-1:0] thrFlat;
  cld_pkg::cld_rfwr_s rfNxt;
  logic signed [31:0] lmA [2];
  logic signed [31:0] lmB [2];
  logic signed [31:0] lmRes [2];
  logic signed [12:0] nRe [`CLD_NDELAY];
  logic signed [12:0] nIm [`CLD_NDELAY];
  logic signed [12:0] nLoRe [`CLD_NDELAY];
  logic signed [12:0] nLoIm [`CLD_NDELAY];
  logic signed [20:0] eRe [`CLD_NDELAY_EXT];
  logic signed [20:0] eIm [`CLD_NDELAY_EXT];
  logic signed [5:0] cutEff;
  logic [31:0] trOld;
  logic [4:0] dstQ;
  logic isDsp;

  assign thrFlat = thrR;
  assign trOld = trR[instr.dst];
  assign cutEff = (instr.op == cld_pkg::CLD_XCORR) ? instr.cut : 6'sh00;
  assign isDsp = instr.op inside {cld_pkg::CLD_DSP_ACC, cld_pkg::CLD_DSP_XFER, cld_pkg::CLD_DSP_DUAL};

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh0_7fff) return 16'h7fff;
    else if (v < 18'sh3_8000) return 16'h8000;
    else return v[15:0];
  endfunction : sat16

  function automatic logic [31:0] sat32(input logic signed [33:0] v);
    if (v > 34'sh0_7fff_ffff) return 32'h7fff_ffff;
    else if (v < 34'sh3_8000_0000) return 32'h8000_0000;
    else return v[31:0];
  endfunction : sat32

  // Cut gate for one code index
  function automatic logic keep(input int w, input logic signed [5:0] c);
    if (c > 6'sh00) return w < int'(c);
    else if (c < 6'sh00) return w >= -int'(c);
    else return 1'b1;
  endfunction : keep

  // Sixteen delay units; unit 15 doubles as the despread engine
  genvar k, m;
  for (k = 0; k < `CLD_NDELAY; k++) begin : g_x
    logic [7:0] gate;
    for (m = 0; m < 8; m++) begin : g_g
      assign gate[m] = keep(m - k + 15, cutEff);
    end
    cld_cmac #(.SW(8), .NS(8)) u_mac (
      .samples(instr.quad),
      .code(thrFlat[2*(15-k) +: 16]),
      .gate(gate),
      .loRe(nLoRe[k]),
      .loIm(nLoIm[k]),
      .allRe(nRe[k]),
      .allIm(nIm[k])
    );
  end
  for (k = 0; k < `CLD_NDELAY_EXT; k++) begin : g_e
    logic [3:0] gate;
    for (m = 0; m < 4; m++) begin : g_g
      assign gate[m] = keep(m - k + 7, cutEff);
    end
    cld_cmac #(.SW(16), .NS(4)) u_mac (
      .samples(instr.quad),
      .code(thrFlat[2*(7-k) +: 8]),
      .gate(gate),
      .loRe(),
      .loIm(),
      .allRe(eRe[k]),
      .allIm(eIm[k])
    );
  end
  for (k = 0; k < 2; k++) begin : g_l
    cld_logmax u_lm (
      .a(lmA[k]),
      .b(lmB[k]),
      .useLog(instr.useLog),
      .res(lmRes[k])
    );
  end

  // Trellis operands per lane
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lmA[i] = trR[5'(instr.srcM + i)];
      lmB[i] = trR[5'(instr.srcN + i)];
      if (instr.op == cld_pkg::CLD_ADD_MAX) begin
        lmA[i] = sat32(34'($signed(trR[5'(instr.srcM + i)])) + 34'($signed(instr.quad[64+32*i +: 32])));
        lmB[i] = sat32(34'($signed(trR[5'(instr.srcN + i)])) + 34'($signed(instr.quad[32*i +: 32])));
      end else if (instr.op == cld_pkg::CLD_SUB_MAX) begin
        lmA[i] = sat32(34'($signed(trR[5'(instr.srcM + i)])) - 34'($signed(instr.quad[64+32*i +: 32])));
        lmB[i] = sat32(34'($signed(trR[5'(instr.srcN + i)])) - 34'($signed(instr.quad[32*i +: 32])));
      end
    end
  end

  always_comb begin
    logic [31:0] base;
    logic [31:0] baseIm;
    base = '0;
    baseIm = '0;
    trNxt = trR;
    thrNxt = thrR;
    rfNxt = '0;
    rfNxt.idx = instr.rdst;
    if (instr.valid) begin
      unique case (instr.op)
        cld_pkg::CLD_TR_LOAD: trNxt[instr.dst] = instr.quad[31:0];
        cld_pkg::CLD_LOGMAX_SR: begin
          rfNxt.valid = 1'b1;
          rfNxt.data = 64'(lmRes[0]);
        end
        cld_pkg::CLD_ADD_MAX, cld_pkg::CLD_SUB_MAX: begin
          for (int i = 0; i < 2; i++) trNxt[5'(instr.dst + i)] = lmRes[i];
        end
        cld_pkg::CLD_DSP_ACC: begin
          trNxt[instr.dst] = {sat16(18'($signed(trOld[31:16])) + 18'(nIm[15])),
                              sat16(18'($signed(trOld[15:0])) + 18'(nRe[15]))};
        end
        cld_pkg::CLD_DSP_XFER: begin
          rfNxt.valid = 1'b1;
          rfNxt.data = 64'(trOld);
          trNxt[instr.dst] = {sat16(18'(nIm[15])), sat16(18'(nRe[15]))};
        end
        cld_pkg::CLD_DSP_DUAL: begin
          rfNxt.valid = 1'b1;
          rfNxt.dbl = 1'b1;
          rfNxt.data = {trR[5'(instr.dst + 1)], trOld};
          trNxt[instr.dst] = {sat16(18'(nLoIm[15])), sat16(18'(nLoRe[15]))};
          trNxt[5'(instr.dst + 1)] = {sat16(18'(nIm[15] - nLoIm[15])), sat16(18'(nRe[15] - nLoRe[15]))};
        end
        cld_pkg::CLD_XCORR: begin
          if (!instr.widePrecision) begin
            for (int d = 0; d < `CLD_NDELAY; d++) begin
              base = instr.zeroBeforeSum ? 32'h0 : trR[5'(instr.dst + d)];
              trNxt[5'(instr.dst + d)] = {sat16(18'($signed(base[31:16])) + 18'(nIm[d])),
                                          sat16(18'($signed(base[15:0])) + 18'(nRe[d]))};
            end
          end else begin
            for (int d = 0; d < `CLD_NDELAY_EXT; d++) begin
              base = instr.zeroBeforeSum ? 32'h0 : trR[5'(instr.dst + 2*d)];
              baseIm = instr.zeroBeforeSum ? 32'h0 : trR[5'(instr.dst + 2*d + 1)];
              trNxt[5'(instr.dst + 2*d)] = sat32(34'($signed(base)) + 34'(eRe[d]));
              trNxt[5'(instr.dst + 2*d + 1)] = sat32(34'($signed(baseIm)) + 34'(eIm[d]));
            end
          end
          thrNxt = {16'h0000, thrFlat[127:`CLD_HIST_SHIFT]};
        end
        default: begin
        end
      endcase
      if (isDsp) begin
        {thrNxt[1], thrNxt[0]} = {16'h0000, thrFlat[63:`CLD_HIST_SHIFT]};
      end
    end
    if (hLoad.valid) thrNxt[hLoad.idx] = hLoad.data;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `CLD_NTR; i++) trR[i] <= `CLD_TR_RESET;
      thrR <= '0;
      rfWr_r <= '0;
      dstQ <= '0;
    end else begin
      trR <= trNxt;
      thrR <= thrNxt;
      rfWr_r <= rfNxt;
      dstQ <= instr.dst;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  single_logmax_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_LOGMAX_SR)
    |=> rfWr_r.valid && rfWr_r.data[31:0] == $past(lmRes[0])) else $error("log-max result not written");
  add_max_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_ADD_MAX && !instr.useLog)
    |-> lmRes[0] >= lmA[0] && lmRes[0] >= lmB[0] ##1 trR[dstQ] == $past(lmRes[0])) else $error("add max wrong");
  sub_max_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_SUB_MAX && !instr.useLog)
    |-> (lmRes[0] == lmA[0] || lmRes[0] == lmB[0]) && lmRes[0] >= lmA[0] && lmRes[0] >= lmB[0])
    else $error("sub max wrong");
  pair_shift_a: assert property ((instr.valid && isDsp && !hLoad.valid)
    |=> thrFlat[63:0] == {16'h0000, $past(thrFlat[63:16])} && thrFlat[127:64] == $past(thrFlat[127:64]))
    else $error("history pair not shifted");
  load_wins_a: assert property (hLoad.valid |=> thrR[$past(hLoad.idx)] == $past(hLoad.data))
    else $error("history load lost");
  xfer_old_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_DSP_XFER)
    |=> rfWr_r.valid && rfWr_r.data[31:0] == $past(trOld) && trR[dstQ] == {$past(16'(nIm[15])), $past(16'(nRe[15]))})
    else $error("transfer lost old metric");
  group_shift_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_XCORR && !hLoad.valid)
    |=> thrFlat == {16'h0000, $past(thrFlat[127:16])}) else $error("history group not shifted");
  clear_sum_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_XCORR && instr.zeroBeforeSum
    && !instr.widePrecision) |=> trR[dstQ] == {$past(16'(nIm[0])), $past(16'(nRe[0]))})
    else $error("clear did not zero");
  dual_sum_a: assert property ((instr.valid && instr.op == cld_pkg::CLD_DSP_DUAL)
    |=> rfWr_r.dbl ##0 trR[dstQ][15:0] == $past(16'(nLoRe[15]))) else $error("dual low word wrong");

  wide_corr_c: cover property (instr.valid && instr.op == cld_pkg::CLD_XCORR && instr.widePrecision);
  dual_dsp_c: cover property (instr.valid && instr.op == cld_pkg::CLD_DSP_DUAL ##1 rfWr_r.valid);
  log_corr_c: cover property (instr.valid && instr.op == cld_pkg::CLD_LOGMAX_SR && instr.useLog);
  load_shift_c: cover property (instr.valid && isDsp && hLoad.valid);
endmodule : cld_datapath
`default_nettype wire

// *** verif/cld_regfile_model.sv ***
// Data register file model that collects results written by the datapath
`timescale 1ns/1ps
`default_nettype none
module cld_regfile_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cld_pkg::cld_rfwr_s rfWr
);
  logic [63:0] mem [32];
  // Known pattern after reset so a missing write never matches by chance
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= 64'ha5a5_a5a5_a5a5_a5a5;
      end
    end else if (rfWr.valid === 1'b1) begin
      mem[rfWr.idx] <= rfWr.data;
    end
  end
endmodule : cld_regfile_model
`default_nettype wire

// *** verif/test_cld_datapath.sv ***
// Self-checking bench for the communications logic datapath
`timescale 1ns/1ps
`default_nettype none
module test_cld_datapath;
  localparam logic [127:0] DSQ = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam logic [31:0] XV = 32'h0004_0002;
  logic sys_clk;
  logic sys_rst;
  cld_pkg::cld_instr_s instr;
  cld_pkg::cld_hload_s hLoad;
  cld_pkg::cld_rfwr_s rfWr_r;
  cld_pkg::cld_rfwr_s pulse;
  logic validAfter;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  cld_datapath cld_datapath_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr), .hLoad(hLoad), .rfWr_r(rfWr_r));
  cld_regfile_model cld_regfile_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .rfWr(rfWr_r));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // One operation per line, so single log-max never shares a line with another unit op
  task automatic issue(input cld_pkg::cld_op_e op, input logic [4:0] dst, input logic [4:0] m, input logic [4:0] n,
      input logic [127:0] q, input logic [5:0] cut = 6'h00, input logic [2:0] opt = 3'h0,
      input logic [2:0] hl = 3'h0, input logic [31:0] hd = 32'h0);
    @(posedge sys_clk);
    instr <= '{1'b1, op, dst, m, n, dst, opt[2], opt[1], opt[0], cut, q};
    hLoad <= '{hl[2], hl[1:0], hd};
  endtask : issue
  // Idles the inputs, grabs the last result pulse and the cycle after it
  task automatic flush();
    @(posedge sys_clk);
    instr <= '0;
    hLoad <= '0;
    #1 pulse = rfWr_r;
    @(posedge sys_clk);
    #1 validAfter = rfWr_r.valid;
  endtask : flush
  task automatic expMetric(input logic [4:0] x, input logic [31:0] exp, input string what);
    issue(cld_pkg::CLD_LOGMAX_SR, x, x, x, '0);
    flush();
    check(what, pulse.data, {{32{exp[31]}}, exp});
  endtask : expMetric
  task automatic setMetric(input logic [4:0] x, input logic [31:0] v);
    issue(cld_pkg::CLD_TR_LOAD, x, 5'h0, 5'h0, {96'h0, v});
  endtask : setMetric
  task automatic setHist(input logic [1:0] i, input logic [31:0] v);
    issue(cld_pkg::CLD_NOP, 5'h0, 5'h0, 5'h0, '0, 6'h00, 3'h0, {1'b1, i}, v);
  endtask : setHist
  task automatic testXcorr();
    issue(cld_pkg::CLD_XCORR, 5'h10, 5'h0, 5'h0, 128'h0103, 6'h04, 3'h2);
    flush();
    expMetric(5'h1b, 32'h0, "cut above");
    expMetric(5'h1c, XV, "cut below");
    issue(cld_pkg::CLD_XCORR, 5'h10, 5'h0, 5'h0, 128'h0103, 6'h3c);
    flush();
    expMetric(5'h1b, XV, "neg cut kept");
    expMetric(5'h1c, XV, "neg cut dropped");
    issue(cld_pkg::CLD_XCORR, 5'h10, 5'h0, 5'h0, 128'h0103, 6'h00, 3'h2);
    flush();
    expMetric(5'h1b, XV, "cleared sum");
    expMetric(5'h10, XV, "delay zero");
    expMetric(5'h1f, XV, "delay last");
    issue(cld_pkg::CLD_XCORR, 5'h0, 5'h0, 5'h0, 128'h0001_0003, 6'h00, 3'h3);
    flush();
    expMetric(5'he, 32'h2, "wide real");
    expMetric(5'hf, 32'h4, "wide imag");
    expMetric(5'h10, XV, "wide delay count");
  endtask : testXcorr
  task automatic testLogmax();
    setMetric(5'h1, 32'hffff_fffb);
    setMetric(5'h2, 32'hffff_ff9c);
    setMetric(5'h3, 32'h0000_0064);
    issue(cld_pkg::CLD_LOGMAX_SR, 5'h9, 5'h1, 5'h2, '0);
    flush();
    check("logmax data", pulse.data, 64'hffff_ffff_ffff_fffb);
    check("logmax target", {pulse.valid, pulse.dbl, pulse.idx}, {2'b10, 5'h9});
    check("pulse after", validAfter, 1'b0);
    issue(cld_pkg::CLD_LOGMAX_SR, 5'h9, 5'h3, 5'h3, '0, 6'h00, 3'h4);
    flush();
    check("correction near", pulse.data[31:0], 32'h0000_007a);
    issue(cld_pkg::CLD_LOGMAX_SR, 5'h9, 5'h3, 5'h2, '0, 6'h00, 3'h4);
    flush();
    check("correction far", pulse.data[31:0], 32'h0000_0064);
  endtask : testLogmax
  task automatic testTrellis();
    setMetric(5'h4, 32'ha);
    setMetric(5'h5, 32'h7fff_fff0);
    setMetric(5'h6, 32'h1);
    setMetric(5'h7, 32'h2);
    issue(cld_pkg::CLD_ADD_MAX, 5'h8, 5'h4, 5'h6, {32'h20, 32'h5, 32'h3, 32'h64});
    issue(cld_pkg::CLD_SUB_MAX, 5'ha, 5'h4, 5'h6, {32'h20, 32'h5, 32'h3, 32'h64});
    flush();
    expMetric(5'h8, 32'h65, "add lane 0");
    expMetric(5'h9, 32'h7fff_ffff, "add lane 1");
    expMetric(5'ha, 32'h5, "sub lane 0");
    expMetric(5'hb, 32'h7fff_ffd0, "sub lane 1");
  endtask : testTrellis
  task automatic testDespread();
    setMetric(5'h0, 32'h0);
    setHist(2'h0, 32'hffff_0000);
    setHist(2'h1, 32'h0000_1234);
    issue(cld_pkg::CLD_DSP_ACC, 5'h0, 5'h0, 5'h0, DSQ);
    issue(cld_pkg::CLD_DSP_XFER, 5'h0, 5'h0, 5'h0, DSQ);
    flush();
    check("transfer old", cld_regfile_model_inst.mem[0][31:0], 32'h0078_0008);
    expMetric(5'h0, 32'hff88_fff8, "shifted code");
    setMetric(5'h1, 32'h7ff0_7ff0);
    setHist(2'h1, 32'hffff_ffff);
    setHist(2'h0, 32'h0);
    issue(cld_pkg::CLD_DSP_ACC, 5'h1, 5'h0, 5'h0, DSQ, 6'h00, 3'h0, 3'b100, 32'h0000_ffff);
    issue(cld_pkg::CLD_DSP_ACC, 5'h1, 5'h0, 5'h0, DSQ);
    flush();
    expMetric(5'h1, 32'h7f87_7ff0, "load over shift");
    setMetric(5'h2, 32'h1111_2222);
    setMetric(5'h3, 32'h3333_4444);
    setHist(2'h0, 32'h0);
    issue(cld_pkg::CLD_DSP_DUAL, 5'h2, 5'h0, 5'h0, DSQ);
    flush();
    check("dual old pair", pulse.data, 64'h3333_4444_1111_2222);
    check("dual width", pulse.dbl, 1'b1);
    expMetric(5'h2, 32'h005c_0004, "dual low");
    expMetric(5'h3, 32'h001c_0004, "dual high");
  endtask : testDespread
  initial begin
    sys_rst = 1'b1;
    instr = '0;
    hLoad = '0;
    repeat (10) @(posedge sys_clk);
    check("reset pulse", rfWr_r.valid, 1'b0);
    sys_rst <= 1'b0;
    expMetric(5'h5, 32'h0, "reset metric");
    testXcorr();
    testLogmax();
    testTrellis();
    testDespread();
    give_verdict();
  end
endmodule : test_cld_datapath
`default_nettype wire
